// [hw/otp_pkg.sv]
package otp_pkg;

	// ==========================================
	// link register map (device side)
	localparam int BLOCK_LEN = 16;
	localparam logic [7:0] REG2_BASE = 8'h00;
	localparam logic [7:0] REG0_BASE = 8'h40;
	localparam logic [7:0] REG1_BASE = 8'h50;
	localparam logic [3:0] PROTO_IDX = 4'h0;
	localparam logic [3:0] LOCATION_IDX = 4'h1;
	localparam logic [7:0] A_PROG_EN = 8'h11;
	localparam logic [7:0] A_CHECK0 = 8'h30;
	localparam logic [7:0] A_CHANGE_ERR = 8'h33;
	// burned array, read only; region n sits at +16*n
	localparam logic [7:0] A_ARRAY = 8'h80;
	localparam logic [7:0] PROG_EN_RST = 8'h00;

	// region select codes and field positions
	localparam logic [1:0] RG0 = 2'h0;
	localparam logic [1:0] RG1 = 2'h1;
	localparam logic [1:0] RG2 = 2'h2;
	localparam logic [1:0] RG_RSV = 2'h3;
	localparam int PE_GO = 7;
	localparam int PE_EXP = 3;
	localparam int PE_EXL = 2;
	localparam int CHK_LOCK = 7;

	// ==========================================
	// timing
	localparam int NVM_WAIT_MAX_US = 1000;
	localparam int CLK_KHZ = 25000;
	localparam int NVM_WAIT_CYC = NVM_WAIT_MAX_US * CLK_KHZ / 1000;
	localparam int BURN_STEP_DEF = NVM_WAIT_CYC / (2 * BLOCK_LEN);

	// ==========================================
	// host apb map
	localparam logic [7:0] APB_CMD = 8'h00;
	localparam logic [7:0] APB_STAT = 8'h04;
	localparam logic [7:0] APB_PROG = 8'h08;
	localparam int CMD_ADDR_LSB = 8;
	localparam int CMD_WRITE = 16;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_PASS = 2;
	localparam int ST_REFUSED = 3;
	localparam int ST_LOCKED = 4;
	localparam int ST_RDATA_LSB = 8;
	localparam int PRG_EXP = 2;
	localparam int PRG_PREPROG = 3;

	// one step of the block check code, shared by both ends
	function automatic logic [6:0] code_step(input logic [6:0] acc,
		input logic [7:0] b);
		return {acc[5:0], acc[6]} ^ b[6:0] ^ {6'h00, b[7]};
	endfunction

endpackage

// [hw/otp_link_if.sv]
`timescale 1ns/10ps
interface otp_link_if;
	// command from host
	logic cmd_valid;
	logic cmd_write;
	logic [7:0] cmd_addr;
	logic [7:0] cmd_wdata;
	// answer from device
	logic rsp_valid;
	logic [7:0] rsp_data;

	modport device(input cmd_valid, input cmd_write, input cmd_addr,
		input cmd_wdata, output rsp_valid, output rsp_data);
	modport host(output cmd_valid, output cmd_write, output cmd_addr,
		output cmd_wdata, input rsp_valid, input rsp_data);
endinterface

// [hw/user_otp_device.sv]
`timescale 1ns/10ps
// Behaviour
// (R01) region 2 burns whole image incl. protocol, location
// (R02) location excluded: not burned, reads 00h after
// (R03) protocol excluded: not burned; host keeps it untouched
// (R04) host never requests region select 11
// (R05) regions 0, 1 share mirror: separate sequences
// (R06) location zero or nonzero per bus mode
// (R07) region locks itself after its burn
// (R08) locked region flags any mirror change
// (R09) region 2 mirror writable, never burned again
// (R10) host checks lock flag before programming
// (R11) write to other region moves base, keeps data
// (R12) program write: check code, burn, lock
// (R13) program start bit stays set
// (R14) host waits maximum program time
// (R15) host reads back whole region afterwards
// (R16) host loads region 2, writes program enable
// (R17) host repeats sequence per user region
// (R18) select 00/01 burns region 0/1, exclusions ignored
// (R19) mirror writes never touch the array
// (R20) request on locked region is ignored
module user_otp_device
	import otp_pkg::*;
#(
	parameter int unsigned BURN_STEP_CYC = BURN_STEP_DEF
)(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// register link from the host
	otp_link_if.device link,
	// status toward the sensor core
	output logic prog_busy,
	output logic [2:0] region_lock,
	output logic [2:0] change_err
);

	// ==========================================
	// state
	typedef enum logic [0:0] {D_IDLE, D_BURN} dev_st_type;

	typedef struct packed {
		dev_st_type st;
		logic busy;
		logic [7:0] prog_en;
		logic [7:0] base;
		logic [15:0][7:0] shared;
		logic [15:0][7:0] r2;
		logic [2:0][15:0][7:0] nv;
		logic [2:0][6:0] code;
		logic [2:0] lock;
		logic [2:0] err;
		logic [1:0] tgt;
		logic excl_proto;
		logic [3:0] idx;
		logic [15:0] tmr;
		logic [6:0] acc;
		logic rsp_valid;
		logic [7:0] rsp_data;
	} dev_state_type;

	dev_state_type q;
	dev_state_type d;
	logic [15:0][7:0] img;
	logic [7:0] byte_now;
	logic [6:0] acc_n;
	logic [6:0] live_shared;
	logic [6:0] live_r2;
	logic [7:0] rd;
	logic [1:0] req_rg;
	logic in_shared;

	// check code over a whole 16-byte block
	function automatic logic [6:0] block_code(input logic [15:0][7:0] blk);
		logic [6:0] c;
		c = 7'h00;
		for (int i = 0; i < BLOCK_LEN; i++) begin
			c = code_step(c, blk[i]);
		end
		return c;
	endfunction

	// ==========================================
	// read path
	always_comb begin
		rd = 8'h00;
		in_shared = (link.cmd_addr[7:4] == REG0_BASE[7:4]) ||
			(link.cmd_addr[7:4] == REG1_BASE[7:4]);
		if (link.cmd_addr[7:4] == REG2_BASE[7:4]) begin
			rd = q.r2[link.cmd_addr[3:0]];
		end else if (in_shared) begin
			rd = q.shared[link.cmd_addr[3:0]];
		end else if (link.cmd_addr == A_PROG_EN) begin
			rd = q.prog_en;
		end else if (link.cmd_addr == A_CHECK0) begin
			rd = {q.lock[0], q.code[0]};
		end else if (link.cmd_addr == A_CHECK0 + 8'h01) begin
			rd = {q.lock[1], q.code[1]};
		end else if (link.cmd_addr == A_CHECK0 + 8'h02) begin
			rd = {q.lock[2], q.code[2]};
		end else if (link.cmd_addr == A_CHANGE_ERR) begin
			rd = {5'h00, q.err};
		end else if (link.cmd_addr[7:6] == A_ARRAY[7:6] &&
			link.cmd_addr[5:4] != RG_RSV) begin
			// array itself, so a burn can be told from a mirror write
			rd = q.nv[link.cmd_addr[5:4]][link.cmd_addr[3:0]]; // [R19]
		end
	end

	// ==========================================
	// next state
	always_comb begin
		d = q;
		d.rsp_valid = 1'b0;
		req_rg = link.cmd_wdata[1:0];

		// burn source: region 2 mirror or the shared block
		img = (q.tgt == RG2) ? q.r2 : q.shared; // [R01] [R18]
		byte_now = img[q.idx];
		acc_n = code_step(q.acc, byte_now);

		// change detection runs only on locked regions; the shared
		// block is compared only while it holds that region
		live_shared = block_code(q.shared);
		live_r2 = block_code(q.r2);
		if (q.lock[0] && q.base == REG0_BASE && live_shared != q.code[0]) begin
			d.err[0] = 1'b1; // [R08]
		end
		if (q.lock[1] && q.base == REG1_BASE && live_shared != q.code[1]) begin
			d.err[1] = 1'b1; // [R08]
		end
		if (q.lock[2] && live_r2 != q.code[2]) begin
			d.err[2] = 1'b1; // [R08]
		end

		// every command is answered one cycle later
		if (link.cmd_valid) begin
			d.rsp_valid = 1'b1;
			d.rsp_data = link.cmd_write ? link.cmd_wdata : rd;
		end

		// writes are ignored while the array is being burned
		if (link.cmd_valid && link.cmd_write && !q.busy) begin
			if (link.cmd_addr[7:4] == REG2_BASE[7:4]) begin
				// mirror only, even after lock
				d.r2[link.cmd_addr[3:0]] = link.cmd_wdata; // [R09] [R19]
			end else if (in_shared) begin
				d.shared[link.cmd_addr[3:0]] = link.cmd_wdata; // [R19]
				d.base = {link.cmd_addr[7:4], 4'h0}; // [R11]
			end else if (link.cmd_addr == A_PROG_EN) begin
				// start bit is kept as written
				d.prog_en = link.cmd_wdata; // [R13]
				if (link.cmd_wdata[PE_GO] && req_rg != RG_RSV &&
					!q.lock[req_rg]) begin // [R20]
					d.st = D_BURN; // [R12]
					d.busy = 1'b1;
					d.tgt = req_rg;
					d.idx = 4'h0;
					d.acc = 7'h00;
					d.tmr = 16'(BURN_STEP_CYC - 1);
					// exclusions only mean something for region 2
					d.excl_proto = (req_rg == RG2) &&
						link.cmd_wdata[PE_EXP]; // [R18]
					if (req_rg == RG2 && link.cmd_wdata[PE_EXL]) begin
						d.r2[LOCATION_IDX] = 8'h00; // [R02]
					end
				end
			end
		end

		unique case (q.st)
			D_IDLE: begin
			end
			D_BURN: begin
				if (q.tmr != 16'h0000) begin
					d.tmr = q.tmr - 16'h0001;
				end else begin
					d.acc = acc_n; // [R12]
					if (!(q.excl_proto && q.idx == PROTO_IDX)) begin
						d.nv[q.tgt][q.idx] = byte_now; // [R01] [R03]
					end
					if (q.idx == 4'hF) begin
						d.code[q.tgt] = acc_n;
						d.lock[q.tgt] = 1'b1; // [R07]
						d.busy = 1'b0;
						d.st = D_IDLE;
					end else begin
						d.idx = q.idx + 4'h1;
						d.tmr = 16'(BURN_STEP_CYC - 1);
					end
				end
			end
		endcase
	end

	// ==========================================
	// registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// outputs straight from flops
	assign prog_busy = q.busy;
	assign region_lock = q.lock;
	assign change_err = q.err;
	assign link.rsp_valid = q.rsp_valid;
	assign link.rsp_data = q.rsp_data;

endmodule

// [hw/user_otp_host.sv]
`timescale 1ns/10ps
module user_otp_host
	import otp_pkg::*;
#(
	parameter int unsigned NVM_WAIT_CYCLES = NVM_WAIT_CYC
)(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// register link to the device
	otp_link_if.host link
);

	// ==========================================
	// state
	typedef enum logic [1:0] {H_IDLE, H_SEND, H_WAIT, H_DELAY} host_st_type;
	typedef enum logic [2:0] {
		PH_USER, PH_CHECK, PH_GO, PH_READ, PH_FINAL
	} phase_type;

	typedef struct packed {
		host_st_type st;
		phase_type ph;
		logic cmd_valid;
		logic cmd_write;
		logic [7:0] cmd_addr;
		logic [7:0] cmd_wdata;
		logic [1:0] region;
		logic exp;
		logic preprog;
		logic [7:0] base;
		logic [3:0] idx;
		logic [6:0] acc;
		logic [15:0] tmr;
		logic busy;
		logic done;
		logic pass;
		logic refused;
		logic locked;
		logic [7:0] rdata;
		logic proto_touched;
		logic loc_nonzero;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} host_state_type;

	host_state_type q;
	host_state_type d;
	logic wr_take;
	logic [1:0] rg;

	// queue one link command; it leaves two cycles later
	function automatic host_state_type issue(input host_state_type s,
		input logic w, input logic [7:0] a, input logic [7:0] v);
		host_state_type r;
		r = s;
		r.cmd_write = w;
		r.cmd_addr = a;
		r.cmd_wdata = v;
		r.st = H_SEND;
		r.busy = 1'b1;
		return r;
	endfunction

	// ==========================================
	// next state
	always_comb begin
		d = q;
		d.pready = 1'b0;
		d.pslverr = 1'b0;
		d.cmd_valid = 1'b0;
		rg = pwdata[1:0];
		wr_take = psel && penable && q.pready && pwrite;

		// answer one cycle into the access phase
		if (psel && penable && !q.pready) begin
			d.pready = 1'b1;
			d.prdata = 32'h0000_0000;
			if (paddr == APB_STAT) begin
				d.prdata[ST_BUSY] = q.busy;
				d.prdata[ST_DONE] = q.done;
				d.prdata[ST_PASS] = q.pass;
				d.prdata[ST_REFUSED] = q.refused;
				d.prdata[ST_LOCKED] = q.locked;
				d.prdata[ST_RDATA_LSB +: 8] = q.rdata;
			end else if (paddr == APB_CMD) begin
				d.prdata[7:0] = q.cmd_wdata;
				d.prdata[CMD_ADDR_LSB +: 8] = q.cmd_addr;
				d.prdata[CMD_WRITE] = q.cmd_write;
			end else if (paddr == APB_PROG) begin
				d.prdata[1:0] = q.region;
				d.prdata[PRG_EXP] = q.exp;
				d.prdata[PRG_PREPROG] = q.preprog;
			end else begin
				d.pslverr = 1'b1;
			end
		end

		// software orders take effect on the completing edge
		if (wr_take && paddr == APB_CMD) begin
			if (q.busy) begin
				d.refused = 1'b1;
			end else begin
				d.done = 1'b0;
				d.refused = 1'b0;
				d.ph = PH_USER;
				if (pwdata[CMD_WRITE] &&
					pwdata[CMD_ADDR_LSB +: 8] == REG2_BASE + 8'(PROTO_IDX)) begin
					d.proto_touched = 1'b1;
				end
				if (pwdata[CMD_WRITE] &&
					pwdata[CMD_ADDR_LSB +: 8] == REG2_BASE + 8'(LOCATION_IDX)) begin
					d.loc_nonzero = (pwdata[7:0] != 8'h00);
				end
				d = issue(d, pwdata[CMD_WRITE], pwdata[CMD_ADDR_LSB +: 8],
					pwdata[7:0]);
			end
		end else if (wr_take && paddr == APB_PROG) begin
			// one region per sequence, never the reserved code,
			// protocol kept untouched when excluded, and a real
			// location when the bus is preprogrammed
			if (q.busy || rg == RG_RSV || // [R04] [R05]
				(pwdata[PRG_EXP] && q.proto_touched) || // [R03]
				(pwdata[PRG_PREPROG] && rg == RG2 && !q.loc_nonzero)) begin
				d.refused = 1'b1; // [R06]
			end else begin
				d.done = 1'b0;
				d.refused = 1'b0;
				d.pass = 1'b0;
				d.locked = 1'b0;
				d.region = rg;
				d.exp = pwdata[PRG_EXP];
				d.preprog = pwdata[PRG_PREPROG];
				d.base = (rg == RG0) ? REG0_BASE :
					((rg == RG1) ? REG1_BASE : REG2_BASE);
				d.ph = PH_CHECK;
				d = issue(d, 1'b0, A_CHECK0 + {6'h00, rg}, 8'h00); // [R10]
			end
		end

		unique case (q.st)
			H_IDLE: begin
			end
			H_SEND: begin
				d.cmd_valid = 1'b1;
				d.st = H_WAIT;
			end
			H_DELAY: begin
				if (q.tmr != 16'h0000) begin
					d.tmr = q.tmr - 16'h0001; // [R14]
				end else begin
					d.ph = PH_READ;
					d.idx = 4'h0;
					d.acc = 7'h00;
					d = issue(d, 1'b0, q.base, 8'h00); // [R15]
				end
			end
			H_WAIT: begin
				if (link.rsp_valid) begin
					d.rdata = link.rsp_data;
					unique case (q.ph)
						PH_USER: begin
							d.done = 1'b1;
							d.busy = 1'b0;
							d.st = H_IDLE;
						end
						PH_CHECK: begin
							if (link.rsp_data[CHK_LOCK]) begin
								d.locked = 1'b1; // [R10]
								d.done = 1'b1;
								d.busy = 1'b0;
								d.st = H_IDLE;
							end else begin
								d.ph = PH_GO; // [R16] [R17]
								d = issue(d, 1'b1, A_PROG_EN, {1'b1, 3'b000,
									q.exp, !q.preprog, q.region}); // [R06]
							end
						end
						PH_GO: begin
							d.st = H_DELAY;
							d.tmr = 16'(NVM_WAIT_CYCLES - 1); // [R14]
						end
						PH_READ: begin
							d.acc = code_step(q.acc, link.rsp_data);
							if (q.idx == 4'hF) begin
								d.ph = PH_FINAL;
								d = issue(d, 1'b0, A_CHECK0 + {6'h00, q.region},
									8'h00);
							end else begin
								d.idx = q.idx + 4'h1;
								d = issue(d, 1'b0, q.base + {4'h0, q.idx + 4'h1},
									8'h00); // [R15]
							end
						end
						PH_FINAL: begin
							d.pass = link.rsp_data[CHK_LOCK] &&
								link.rsp_data[6:0] == q.acc; // [R15]
							d.done = 1'b1;
							d.busy = 1'b0;
							d.st = H_IDLE;
						end
					endcase
				end
			end
		endcase
	end

	// ==========================================
	// registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// outputs straight from flops
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign link.cmd_valid = q.cmd_valid;
	assign link.cmd_write = q.cmd_write;
	assign link.cmd_addr = q.cmd_addr;
	assign link.cmd_wdata = q.cmd_wdata;

endmodule

// [test/otp_link_sva.sv]
`timescale 1ns/10ps
module otp_link_sva
	import otp_pkg::*;
#(
	parameter int unsigned BURN_STEP_CYC = BURN_STEP_DEF
)(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// link
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_data,
	// device status
	input wire logic prog_busy,
	input wire logic [2:0] region_lock
);
	localparam int BURN_LEN = 16 * BURN_STEP_CYC;
	logic go_req;
	logic no_burn;
	logic [15:0] len_q;
	default clocking dck @(posedge mclk); endclocking
	default disable iff (rst);

	// ==========================================
	// program request decode; select 11 never indexes the lock vector
	assign go_req = cmd_valid && cmd_write && cmd_addr == A_PROG_EN
		&& cmd_wdata[PE_GO] && !prog_busy;
	assign no_burn = cmd_wdata[1:0] == RG_RSV || region_lock[cmd_wdata[1:0]];
	// busy cycles seen so far in this burn
	always_ff @(posedge mclk) begin
		if (rst || !prog_busy) begin
			len_q <= 16'h0000;
		end else begin
			len_q <= len_q + 16'h0001;
		end
	end

	// ==========================================
	// link handshake
	rsp_next_a: assert property (cmd_valid |=> rsp_valid)
		else $error("link command left unanswered");
	rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
		else $error("answer pulse longer than one cycle");
	echo_data_a: assert property (cmd_valid && cmd_write |=>
		rsp_data == $past(cmd_wdata)) else $error("write echo wrong");

	// ==========================================
	// burn start, length and locking
	burn_start_a: assert property (go_req && !no_burn |=> prog_busy)
		else $error("program request did not start a burn");
	burn_refuse_a: assert property (go_req && no_burn |=> !prog_busy)
		else $error("burn started on locked or reserved region");
	burn_len_a: assert property (prog_busy |-> len_q < BURN_LEN)
		else $error("burn runs too long");
	burn_end_a: assert property ($fell(prog_busy) && !$past(rst) |->
		len_q == BURN_LEN) else $error("burn ended early");
	lock_set_a: assert property ($fell(prog_busy) && !$past(rst) |->
		$changed(region_lock)) else $error("burn ended without lock");
	lock_hold_a: assert property (!$past(rst) |->
		($past(region_lock) & ~region_lock) == 3'b000)
		else $error("lock flag cleared");
	lock_cause_a: assert property ($changed(region_lock) &&
		!$past(rst) |-> $fell(prog_busy)) else $error("lock without burn");
endmodule

// [test/testbench.sv]
`timescale 1ns/10ps
module testbench
	import otp_pkg::*;
;
	typedef struct packed {logic [32:0] val; logic [32:0] mask;} note_type;
	logic mclk, rst, psel, penable, pwrite, pready, pslverr, prog_busy;
	logic chk_on;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [2:0] region_lock, change_err;
	logic [15:0] seed;
	logic [7:0] img [16];
	note_type notes [$];
	int errors, compares;

	// ==========================================
	// both ends joined over the link
	otp_link_if i_otp_link_if();
	user_otp_host #(.NVM_WAIT_CYCLES(40)) i_user_otp_host(.mclk(mclk),
		.rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(i_otp_link_if.host));
	user_otp_device #(.BURN_STEP_CYC(1)) i_user_otp_device(.mclk(mclk),
		.rst(rst), .link(i_otp_link_if.device), .prog_busy(prog_busy),
		.region_lock(region_lock), .change_err(change_err));
	otp_link_sva #(.BURN_STEP_CYC(1)) i_otp_link_sva(.mclk(mclk),
		.rst(rst), .cmd_valid(i_otp_link_if.cmd_valid),
		.cmd_write(i_otp_link_if.cmd_write),
		.cmd_addr(i_otp_link_if.cmd_addr),
		.cmd_wdata(i_otp_link_if.cmd_wdata),
		.rsp_valid(i_otp_link_if.rsp_valid),
		.rsp_data(i_otp_link_if.rsp_data), .prog_busy(prog_busy),
		.region_lock(region_lock));

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// ==========================================
	// helpers
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [6:0] fold(input logic [6:0] c,
		input logic [7:0] b);
		return {c[5:0], c[6]} ^ b[6:0] ^ {6'h00, b[7]};
	endfunction
	task automatic check(input logic [32:0] seen, input logic [32:0] want);
		compares++;
		if (seen !== want) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, seen, want);
		end
	endtask
	task automatic print_verdict();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// one apb transfer; request held until pready is sampled high
	task automatic apb_xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			errors++;
			print_verdict();
		end
	endtask
	// read whose result the monitor compares against a queued note
	task automatic note_rd(input logic [7:0] a, input logic [32:0] e,
		input logic [32:0] m);
		logic [31:0] rd;
		notes.push_back('{e & m, m});
		chk_on <= 1'b1;
		apb_xfer(1'b0, a, 32'h0, rd);
		chk_on <= 1'b0;
	endtask
	// poll status until the host is idle again, bounded
	task automatic wait_idle();
		logic [31:0] st;
		int n;
		n = 0;
		do begin
			apb_xfer(1'b0, APB_STAT, 32'h0, st);
			n++;
		end while (st[ST_BUSY] !== 1'b0 && n < 500);
		if (st[ST_BUSY] !== 1'b0) begin
			errors++;
			print_verdict();
		end
	endtask
	task automatic link_op(input logic wr, input logic [7:0] a,
		input logic [7:0] d);
		logic [31:0] rd;
		apb_xfer(1'b1, APB_CMD, {15'h0000, wr, a, d}, rd);
		wait_idle();
	endtask
	task automatic link_rd(input logic [7:0] a, input logic [7:0] e);
		link_op(1'b0, a, 8'h00);
		note_rd(APB_STAT, {17'h0, e, 8'h00}, 33'h1_0000_FF00);
	endtask
	task automatic prog(input logic [3:0] b, input logic [4:0] e,
		input logic [4:0] m);
		logic [31:0] rd;
		apb_xfer(1'b1, APB_PROG, {28'h0, b}, rd);
		wait_idle();
		note_rd(APB_STAT, {28'h0, e}, {1'b1, 27'h0, m});
	endtask

	// ==========================================
	// monitor: oldest note against each checked read
	always @(posedge mclk) begin
		if (chk_on && psel && penable && pready === 1'b1) begin
			check({pslverr, prdata} & notes[0].mask, notes[0].val);
			void'(notes.pop_front());
		end
	end

	// ==========================================
	// main sequence
	initial begin
		int i;
		logic [6:0] code;
		logic [7:0] nv;
		{rst, psel, penable, pwrite, chk_on} = 5'b10000;
		paddr = 8'h00;
		pwdata = 32'h0;
		errors = 0;
		compares = 0;
		seed = 16'h0005;
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		note_rd(8'h0C, {1'b1, 32'h0}, '1);
		note_rd(APB_STAT, 33'h0, '1);
		// region 2 with location excluded; code sees it as zero
		code = 7'h00;
		for (i = 0; i < 16; i++) begin
			seed = lfsr_next(seed);
			img[i] = seed[7:0] | 8'h01;
			link_op(1'b1, REG2_BASE + 8'(i), img[i]);
			code = fold(code, (i == 1) ? 8'h00 : img[i]);
		end
		// protocol excluded after it was written: refused
		prog(4'h6, 5'b01000, 5'b01001);
		prog(4'h2, 5'b00110, 5'h1F);
		link_rd(A_CHECK0 + 8'h02, {1'b1, code});
		link_rd(REG2_BASE + 8'h01, 8'h00);
		link_rd(REG2_BASE, img[0]);
		link_rd(A_ARRAY + 8'h20, img[0]);
		link_rd(A_PROG_EN, 8'h86);
		check({30'h0, region_lock}, 33'h4);
		// locked region: mirror writable, flagged, never burned
		link_op(1'b1, REG2_BASE, ~img[0]);
		check({30'h0, change_err}, 33'h4);
		link_rd(REG2_BASE, ~img[0]);
		link_op(1'b1, A_PROG_EN, 8'h82);
		prog(4'h2, 5'b10000, 5'b10001);
		link_rd(A_CHECK0 + 8'h02, {1'b1, code});
		link_rd(A_ARRAY + 8'h20, img[0]);
		// region 0 through the shared block
		code = 7'h00;
		for (i = 0; i < 16; i++) begin
			seed = lfsr_next(seed);
			img[i] = seed[7:0];
			link_op(1'b1, REG0_BASE + 8'(i), img[i]);
			code = fold(code, img[i]);
		end
		prog(4'h8, 5'b00110, 5'h1F);
		link_rd(A_CHECK0, {1'b1, code});
		link_rd(A_ARRAY + 8'h0F, img[15]);
		// one write moves the base to region 1; the rest is kept
		nv = ~img[15];
		link_op(1'b1, REG1_BASE + 8'h0F, nv);
		code = 7'h00;
		for (i = 0; i < 16; i++) begin
			code = fold(code, (i == 15) ? nv : img[i]);
		end
		prog(4'h9, 5'b00110, 5'h1F);
		link_rd(A_CHECK0 + 8'h01, {1'b1, code});
		link_rd(REG1_BASE, img[0]);
		link_rd(A_ARRAY + 8'h1F, nv);
		prog(4'h3, 5'b01000, 5'b01001);
		check({30'h0, region_lock}, 33'h7);
		// shared block moved away from region 0: no false flag
		check({30'h0, change_err}, 33'h4);
		// mid-run reset, then region 2 with protocol excluded
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		check({27'h0, change_err, region_lock}, 33'h0);
		// preprogrammed bus with location still zero: refused
		prog(4'hA, 5'b01000, 5'b01001);
		// protocol byte left at its reset value, code folds it as 0
		code = 7'h00;
		for (i = 1; i < 16; i++) begin
			seed = lfsr_next(seed);
			img[i] = seed[7:0] | 8'h01;
			link_op(1'b1, REG2_BASE + 8'(i), img[i]);
			code = fold(code, img[i]);
		end
		prog(4'hE, 5'b00110, 5'h1F);
		link_rd(A_CHECK0 + 8'h02, {1'b1, code});
		link_rd(A_ARRAY + 8'h21, img[1]);
		link_rd(A_ARRAY + 8'h20, 8'h00);
		link_rd(A_PROG_EN, 8'h8A);
		print_verdict();
	end
endmodule
